// ==== logic/ffc_pkg.sv ====
// Package for the format and filter control register bank.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package ffc_pkg;
  // Register byte offsets
  localparam logic [3:0] FFC_OFS_LEFT = 4'h0;
  localparam logic [3:0] FFC_OFS_RIGHT = 4'h4;
  localparam logic [3:0] FFC_OFS_CTRL = 4'h8;
  localparam logic [3:0] FFC_OFS_STATUS = 4'hC;
  // Control word fields
  localparam int FFC_BIT_FAMILY = 0;
  localparam int FFC_BIT_POL = 1;
  localparam int FFC_BIT_COUPLE = 2;
  localparam int FFC_BIT_ROLL = 3;
  localparam int FFC_BIT_CKDIV = 4;
  localparam int FFC_BIT_SF_LO = 5;
  localparam int FFC_CTRL_W = 16;
  // Reset values
  localparam logic [15:0] FFC_CTRL_RST = 16'h0000;
  localparam logic [7:0] FFC_LEVEL_RST = 8'hFF;
  // De-emphasis rate codes
  localparam logic [1:0] FFC_SF_441 = 2'h0;
  localparam logic [1:0] FFC_SF_RSVD = 2'h1;
  localparam logic [1:0] FFC_SF_48 = 2'h2;
  localparam logic [1:0] FFC_SF_32 = 2'h3;
  // Attenuation step is 0.5 dB per count; full scale code
  localparam logic [7:0] FFC_LEVEL_FULL = 8'hFF;
  localparam logic [7:0] FFC_LEVEL_MUTE = 8'h00;
endpackage

// ==== logic/ffc_level.sv ====
// Per-channel attenuation decode from a level value.
// Assumes inputs on the same clock; output registered by the caller.
`timescale 1ns/1ns
`default_nettype none
module ffc_level
  import ffc_pkg::*;
(
  input wire logic [7:0] level,
  output logic [7:0] atten_half_db,
  output logic mute
);
  always_comb begin
    atten_half_db = FFC_LEVEL_FULL - level;
    mute = (level == FFC_LEVEL_MUTE);
  end
endmodule
`default_nettype wire

// ==== logic/ffc_top.sv ====
// Format and filter control register bank with attenuator level decode.
// Assumes a classic Wishbone master on clk; all inputs are synchronous.
//
// What this block does
// - Family bit 0 selects standard or left-justified input, 1 selects I2S.
// - Polarity bit 0 means word-select high is left, 1 reverses it.
// - Coupling bit 1 makes both channels use the left level, 0 keeps them independent.
// - Roll-off bit 0 selects sharp response, 1 selects slow response.
// - Clock-out bit selects full or half crystal clock frequency.
// - Rate code 00 is 44.1 kHz, 10 is 48 kHz, 11 is 32 kHz, 01 reserved.
// - Attenuation is 0.5 dB times (255 - level), level 00h mutes.
// - Independent mode takes each channel level from its own field.
`timescale 1ns/1ns
`default_nettype none
module ffc_top
  import ffc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic i2s_family,
  output logic left_when_high,
  output logic slow_rolloff,
  output logic clock_out_half,
  output logic deemph_441,
  output logic deemph_48,
  output logic deemph_32,
  output logic [7:0] left_atten,
  output logic [7:0] right_atten,
  output logic left_mute,
  output logic right_mute
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [31:0] dat;
    logic ack;
    logic [15:0] ctrl;
    logic [7:0] left_level;
    logic [7:0] right_level;
    logic i2s_family;
    logic left_when_high;
    logic slow_rolloff;
    logic clock_out_half;
    logic deemph_441;
    logic deemph_48;
    logic deemph_32;
    logic [7:0] left_atten;
    logic [7:0] right_atten;
    logic left_mute;
    logic right_mute;
  } ffc_state_t;

  ffc_state_t st;
  ffc_state_t next_st;
  logic [7:0] eff_right;
  logic [1:0][7:0] lvl_src;
  wire logic [1:0][7:0] att;
  wire logic [1:0] mute_v;
  logic wr_hit;
  logic [1:0] sf;

  ////////////////////////////////////////////////////////////////////////////
  // level source
  assign eff_right = st.ctrl[FFC_BIT_COUPLE] ? st.left_level : st.right_level;
  assign sf = st.ctrl[FFC_BIT_SF_LO +: 2];
  assign wr_hit = wb_cyc_i && wb_stb_i && !st.ack;

  assign lvl_src = {eff_right, st.left_level};
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    ffc_level ffc_level_i (
      .level(lvl_src[ch]),
      .atten_half_db(att[ch]),
      .mute(mute_v[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    // One wait-free ack, dropped the cycle after
    next_st.ack = wr_hit;
    if (wr_hit) begin
      next_st.dat = 32'h0000_0000;
      if (wb_we_i) begin
        case (wb_adr_i)
          FFC_OFS_LEFT: if (wb_sel_i[0]) next_st.left_level = wb_dat_i[7:0];
          FFC_OFS_RIGHT: if (wb_sel_i[0]) next_st.right_level = wb_dat_i[7:0];
          FFC_OFS_CTRL: begin
            if (wb_sel_i[0]) next_st.ctrl[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1]) next_st.ctrl[15:8] = wb_dat_i[15:8];
          end
          default: ;
        endcase
      end else begin
        case (wb_adr_i)
          FFC_OFS_LEFT: next_st.dat = {24'h000000, st.left_level};
          FFC_OFS_RIGHT: next_st.dat = {24'h000000, st.right_level};
          FFC_OFS_CTRL: next_st.dat = {16'h0000, st.ctrl};
          // Live state: decoded attenuations and mutes
          FFC_OFS_STATUS: next_st.dat = {14'h0000, st.right_mute, st.left_mute,
                                         st.right_atten, st.left_atten};
          default: next_st.dat = 32'h0000_0000;
        endcase
      end
    end
    next_st.i2s_family = st.ctrl[FFC_BIT_FAMILY];
    next_st.left_when_high = !st.ctrl[FFC_BIT_POL];
    next_st.slow_rolloff = st.ctrl[FFC_BIT_ROLL];
    next_st.clock_out_half = st.ctrl[FFC_BIT_CKDIV];
    // rate decode; reserved code drives none
    next_st.deemph_441 = (sf == FFC_SF_441);
    next_st.deemph_48 = (sf == FFC_SF_48);
    next_st.deemph_32 = (sf == FFC_SF_32);
    next_st.left_atten = att[0];
    next_st.right_atten = att[1];
    next_st.left_mute = mute_v[0];
    next_st.right_mute = mute_v[1];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{dat: 32'h0000_0000, ack: 1'b0, ctrl: FFC_CTRL_RST,
              left_level: FFC_LEVEL_RST, right_level: FFC_LEVEL_RST,
              i2s_family: 1'b0, left_when_high: 1'b1, slow_rolloff: 1'b0,
              clock_out_half: 1'b0, deemph_441: 1'b1, deemph_48: 1'b0,
              deemph_32: 1'b0, left_atten: 8'h00, right_atten: 8'h00,
              left_mute: 1'b0, right_mute: 1'b0};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign i2s_family = st.i2s_family;
  assign left_when_high = st.left_when_high;
  assign slow_rolloff = st.slow_rolloff;
  assign clock_out_half = st.clock_out_half;
  assign deemph_441 = st.deemph_441;
  assign deemph_48 = st.deemph_48;
  assign deemph_32 = st.deemph_32;
  assign left_atten = st.left_atten;
  assign right_atten = st.right_atten;
  assign left_mute = st.left_mute;
  assign right_mute = st.right_mute;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions, gated on clk_en since state freezes otherwise
  property p_family;
    @(posedge clk) disable iff (!reset_n)
      clk_en ##1 clk_en |-> i2s_family == $past(st.ctrl[FFC_BIT_FAMILY]);
  endproperty
  a_family: assert property (p_family) else $error("family mismatch");

  property p_polarity;
    @(posedge clk) disable iff (!reset_n)
      clk_en ##1 clk_en |-> left_when_high != $past(st.ctrl[FFC_BIT_POL]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity wrong");

  property p_couple;
    @(posedge clk) disable iff (!reset_n)
      clk_en && st.ctrl[FFC_BIT_COUPLE] ##1 clk_en |->
        right_atten == FFC_LEVEL_FULL - $past(st.left_level);
  endproperty
  a_couple: assert property (p_couple) else $error("coupling wrong");

  property p_roll;
    @(posedge clk) disable iff (!reset_n)
      clk_en ##1 clk_en |-> slow_rolloff == $past(st.ctrl[FFC_BIT_ROLL]);
  endproperty
  a_roll: assert property (p_roll) else $error("rolloff wrong");

  property p_ckdiv;
    @(posedge clk) disable iff (!reset_n)
      clk_en ##1 clk_en |-> clock_out_half == $past(st.ctrl[FFC_BIT_CKDIV]);
  endproperty
  a_ckdiv: assert property (p_ckdiv) else $error("clock divide wrong");

  property p_rate;
    @(posedge clk) disable iff (!reset_n)
      clk_en && sf == FFC_SF_48 ##1 clk_en |-> deemph_48 && !deemph_441 && !deemph_32;
  endproperty
  a_rate: assert property (p_rate) else $error("rate decode wrong");

  property p_mute;
    @(posedge clk) disable iff (!reset_n)
      clk_en && st.left_level == FFC_LEVEL_MUTE ##1 clk_en |-> left_mute;
  endproperty
  a_mute: assert property (p_mute) else $error("mute missing");

  property p_indep;
    @(posedge clk) disable iff (!reset_n)
      clk_en && !st.ctrl[FFC_BIT_COUPLE] ##1 clk_en |->
        right_atten == FFC_LEVEL_FULL - $past(st.right_level);
  endproperty
  a_indep: assert property (p_indep) else $error("independent wrong");

  property p_ack_once;
    @(posedge clk) disable iff (!reset_n)
      clk_en && wb_ack_o ##1 clk_en |-> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held");

  c_write_ctrl: cover property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o && wb_we_i && wb_adr_i == FFC_OFS_CTRL);
  c_coupled: cover property (@(posedge clk) disable iff (!reset_n)
    st.ctrl[FFC_BIT_COUPLE] && right_mute);
  c_rate32: cover property (@(posedge clk) disable iff (!reset_n) deemph_32);
  c_frozen_req: cover property (@(posedge clk) disable iff (!reset_n)
    !clk_en && wb_cyc_i && wb_stb_i);
endmodule
`default_nettype wire

// ==== test/ffc_host.sv ====
// Host model: classic Wishbone master for the control register bank.
// Assumes the bench calls access only after reset release.
`timescale 1ns/1ns
`default_nettype none
module ffc_host
  import ffc_pkg::*;
(
  input wire logic clk,
  input wire logic ack,
  input wire logic [31:0] rdat,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [3:0] adr,
  output logic [31:0] wdat,
  output logic [3:0] sel
);
  initial begin
    {cyc, stb, we, adr, wdat, sel} = '0;
  end
  task automatic access(input logic w, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    logic [31:0] dd;
    dd = d;
    if (w && a == FFC_OFS_CTRL && dd[6:5] == FFC_SF_RSVD) dd[6:5] = FFC_SF_441;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dd;
    sel <= 4'hF;
    // Ends on ack; only the bench timeout ends this wait if ack never comes
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== test/filter_format_filter_control_config_bench.sv ====
// Bench for the format and filter control register bank.
// Assumes ffc_host as bus master; clk_en high except in the freeze test.
`timescale 1ns/1ns
`default_nettype none
module filter_format_filter_control_config_bench
  import ffc_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic cyc, stb, we, ack;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, q;
  logic fam, lwh, slow, half, d441, d48, d32, lm, rm;
  logic [7:0] la, ra;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  wire logic [6:0] dec_out = {fam, lwh, slow, half, d441, d48, d32};
  wire logic [17:0] lvl = {lm, la, rm, ra};
  ffc_top ffc_top_i (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .i2s_family(fam), .left_when_high(lwh),
    .slow_rolloff(slow), .clock_out_half(half), .deemph_441(d441), .deemph_48(d48),
    .deemph_32(d32), .left_atten(la), .right_atten(ra), .left_mute(lm), .right_mute(rm));
  ffc_host ffc_host_i (.clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .wdat(wdat), .sel(sel));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Generous ceiling; the whole run needs about a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    ffc_host_i.access(1'b1, a, d, q);
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    ffc_host_i.access(1'b0, a, 32'h0, q);
  endtask
  function automatic logic [6:0] dec(input logic [15:0] c);
    return {c[0], ~c[1], c[3], c[4], c[6:5] == FFC_SF_441, c[6:5] == FFC_SF_48,
            c[6:5] == FFC_SF_32};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(dec_out, dec(FFC_CTRL_RST));
    rd(FFC_OFS_STATUS);
    chk(q, 32'h0);
  endtask
  task automatic t_ctrl();
    logic [15:0] v[8] = '{16'h0001, 16'h0002, 16'h0008, 16'h0010, 16'h0040,
                          16'h0060, 16'h007B, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      wr(FFC_OFS_CTRL, {16'h0, v[i]});
      chk(dec_out, dec(v[i]));
    end
  endtask
  task automatic t_levels();
    wr(FFC_OFS_LEFT, 32'h0);
    wr(FFC_OFS_RIGHT, 32'h1);
    chk(lvl, {1'b1, 8'hFF, 1'b0, 8'hFE});
    wr(FFC_OFS_CTRL, 32'h4);
    chk(lvl, {1'b1, 8'hFF, 1'b1, 8'hFF});
    wr(FFC_OFS_LEFT, 32'h80);
    chk(lvl, {1'b0, 8'h7F, 1'b0, 8'h7F});
    rd(FFC_OFS_RIGHT);
    chk(q, 32'h1);
    rd(FFC_OFS_STATUS);
    chk(q, 32'h7F7F);
  endtask
  task automatic t_unmapped();
    wr(4'h2, 32'hFFFF);
    chk(dec_out, dec(16'h0004));
    rd(4'h2);
    chk(q, 32'h0);
  endtask
  // Request held while frozen must wait, then land once enabled
  task automatic t_freeze();
    @(posedge clk);
    clk_en <= 1'b0;
    fork
      wr(FFC_OFS_CTRL, 32'h0001);
      begin
        repeat (4) @(posedge clk);
        chk({ack, dec_out}, {1'b0, dec(16'h0004)});
        clk_en <= 1'b1;
      end
    join
    chk(dec_out, dec(16'h0001));
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_ctrl();
    t_levels();
    t_unmapped();
    t_freeze();
    print_verdict();
  end
endmodule
`default_nettype wire
